// File: logic/spfp_dev_packer.sv
// Purpose: Packer end: takes user words, builds 16-byte lines, emits link words.
// Assumes: Width mode stays constant within a packet.
// Notes:   A line waits for the link serializer before the next word is taken.
`include "spfp_regs.svh"
`default_nettype none
module spfp_dev_packer (
    // Clock and reset.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_srst,
    // User word port.
    spfp_word_if.dev                        u_word,
    // Link word stream.
    output logic [`SPFP_LINK_BITS-1:0]      o_link_data,
    output logic                            o_link_valid,
    output logic                            o_link_sop,
    output logic                            o_link_eop,
    output logic                            o_link_err,
    output logic                            o_link_pad,
    // Status.
    output logic [`SPFP_PTR_BITS-1:0]       o_wr_ptr,
    output logic                            o_fmt_err,
    input  wire logic                       i_fmt_err_clr
);
    import spfp_pkg::*;

    // ------------------------------------------------------------
    // Line assembly state
    // ------------------------------------------------------------
    spfp_line_t                 line_q;
    spfp_line_t                 line_d;
    logic [4:0]                 nb_q;
    logic [4:0]                 nb_d;
    logic [1:0]                 slot_q;
    logic [1:0]                 slot_d;
    logic                       pend_q;
    logic                       pend_d;
    logic                       lsop_q;
    logic                       lsop_d;
    logic                       leop_q;
    logic                       leop_d;
    logic                       lerr_q;
    logic                       lerr_d;
    logic                       inpkt_q;
    logic                       inpkt_d;
    logic                       perr_q;
    logic                       perr_d;
    logic [`SPFP_PTR_BITS-1:0]  ptr_q;
    logic [`SPFP_PTR_BITS-1:0]  ptr_d;
    logic                       fmt_q;
    logic                       fmt_d;
    logic                       ser_ready;
    logic                       take;
    logic                       bad;
    logic [4:0]                 wb;
    logic [4:0]                 n;
    logic [15:0]                be;
    logic [15:0]                want;
    logic [3:0]                 idx;

    // A pending line blocks new words, which is how the link pushes back.
    assign u_word.ready = !pend_q;
    assign take         = u_word.valid && !pend_q;
    assign o_wr_ptr     = ptr_q;
    assign o_fmt_err    = fmt_q;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Words land in the line at their burst slot, top lane first.
    always_comb begin
        wb = spfp_word_bytes(u_word.mode);
        be = u_word.byte_lane_enables & spfp_lead_mask(wb, wb);
        n = spfp_ones(be);
        want = u_word.eop ? spfp_lead_mask(n, wb) : spfp_lead_mask(wb, wb);
        idx = '0;
        bad = 1'b0;
        line_d = line_q;
        nb_d = nb_q;
        slot_d = slot_q;
        pend_d = pend_q;
        lsop_d = lsop_q;
        leop_d = leop_q;
        lerr_d = lerr_q;
        inpkt_d = inpkt_q;
        perr_d = perr_q;
        ptr_d = ptr_q;
        // Handed to the serializer: the line is free again.
        if (pend_q && ser_ready) begin
            pend_d = 1'b0;
            line_d = '0;
            nb_d = '0;
            lsop_d = 1'b0;
            leop_d = 1'b0;
            lerr_d = 1'b0;
        end
        if (take) begin
            for (int i = 0; i < 16; i++) begin
                if (i < int'(wb)) begin
                    idx = 4'(int'(slot_q) * int'(wb) + i);
                    line_d[idx] = u_word.data[(int'(wb) - 1 - i) * 8 +: 8];
                end
            end
            // Only enabled bytes count, so a trailing pad never does.
            nb_d = nb_q + n;
            if (u_word.byte_lane_enables != want[15:0] && wb != 5'h10) begin
                bad = 1'b1;
            end
            if (be != want) begin
                bad = 1'b1;
            end
            if (u_word.eop && n == 5'h00) begin
                bad = 1'b1;
            end
            if (u_word.sop && (slot_q != 2'h0 || inpkt_q)) begin
                bad = 1'b1;
            end
            if (!u_word.sop && !inpkt_q) begin
                bad = 1'b1;
            end
            if (inpkt_q && perr_q && !u_word.err) begin
                bad = 1'b1;
            end
            if (u_word.sop) begin
                lsop_d = 1'b1;
            end
            lerr_d = lerr_q || perr_q || u_word.err;
            leop_d = u_word.eop;
            inpkt_d = !u_word.eop && (u_word.sop || inpkt_q);
            perr_d = !u_word.eop && (perr_q || u_word.err);
            // Burst ends on its last slot or early at the packet end.
            if (u_word.eop || slot_q == spfp_last_slot(u_word.mode)) begin
                slot_d = 2'h0;
                if (nb_d != 5'h00) begin
                    pend_d = 1'b1;
                    ptr_d = ptr_q + 1'b1;
                end else begin
                    line_d = '0;
                    lsop_d = 1'b0;
                    lerr_d = 1'b0;
                end
            end else begin
                slot_d = slot_q + 2'h1;
            end
        end
        // A new violation wins over a clear in the same cycle.
        fmt_d = (take && bad) || (fmt_q && !i_fmt_err_clr);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // All state is cleared by the synchronous reset.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            line_q <= '0;
            nb_q <= '0;
            slot_q <= '0;
            pend_q <= 1'b0;
            lsop_q <= 1'b0;
            leop_q <= 1'b0;
            lerr_q <= 1'b0;
            inpkt_q <= 1'b0;
            perr_q <= 1'b0;
            ptr_q <= '0;
            fmt_q <= 1'b0;
        end else begin
            line_q <= line_d;
            nb_q <= nb_d;
            slot_q <= slot_d;
            pend_q <= pend_d;
            lsop_q <= lsop_d;
            leop_q <= leop_d;
            lerr_q <= lerr_d;
            inpkt_q <= inpkt_d;
            perr_q <= perr_d;
            ptr_q <= ptr_d;
            fmt_q <= fmt_d;
        end
    end

    // ------------------------------------------------------------
    // Link serializer
    // ------------------------------------------------------------
    // The serializer copies the line, so the line frees on the same edge that loads it.
    spfp_link_ser u_ser (
        .i_core_clk   (i_core_clk),
        .i_srst       (i_srst),
        .i_load       (pend_q),
        .i_line       (line_q),
        .i_nb         (nb_q),
        .i_sop        (lsop_q),
        .i_eop        (leop_q),
        .i_err        (lerr_q),
        .o_ready      (ser_ready),
        .o_link_data  (o_link_data),
        .o_link_valid (o_link_valid),
        .o_link_sop   (o_link_sop),
        .o_link_eop   (o_link_eop),
        .o_link_err   (o_link_err),
        .o_link_pad   (o_link_pad)
    );
endmodule
`default_nettype wire

// File: logic/spfp_host_feeder.sv
// Purpose: Fabric end: gathers packet bytes into lines and writes them as user words.
// Assumes: Mode input is steady while a packet is gathered.
// Notes:   A whole line is gathered first so every burst is written back to back.
`include "spfp_regs.svh"
`default_nettype none
module spfp_host_feeder (
    // Clock and reset.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_srst,
    // Byte source.
    input  wire logic                       i_byte_valid,
    output logic                            o_byte_ready,
    input  wire logic [7:0]                 i_byte_data,
    input  wire logic                       i_byte_last,
    input  wire logic                       i_byte_err,
    input  wire spfp_pkg::spfp_mode_t       i_mode,
    // User word port.
    spfp_word_if.host                       u_word
);
    import spfp_pkg::*;

    spfp_hstate_t st_q, st_d;
    spfp_line_t   line_q, line_d;
    logic [4:0]   nb_q, nb_d, wb;
    logic [1:0]   w_q, w_d, fw;
    logic         first_q, first_d, last_q, last_d, err_q, err_d;
    spfp_mode_t   mode_q, mode_d;
    logic [3:0]   idx;

    // Words are driven from the gathered line and the burst slot.
    always_comb begin
        wb = spfp_word_bytes(mode_q);
        fw = 2'((nb_q - 5'h01) >> (int'(mode_q) + 2));
        idx = '0;
        u_word.data = '0;
        u_word.byte_lane_enables = '0;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(wb)) begin
                idx = 4'(int'(w_q) * int'(wb) + i);
                u_word.data[(int'(wb) - 1 - i) * 8 +: 8] = line_q[idx];
                u_word.byte_lane_enables[int'(wb) - 1 - i] = 5'(idx) < nb_q;
            end
        end
        u_word.valid = (st_q == SPFP_H_SEND);
        u_word.sop = u_word.valid && first_q && (w_q == 2'h0);
        u_word.eop = u_word.valid && last_q && (w_q == fw);
        u_word.err = u_word.valid && err_q;
        u_word.mode = mode_q;
        o_byte_ready = (st_q == SPFP_H_FILL);
    end

    // Gather until sixteen bytes or the packet end, then send the burst.
    always_comb begin
        st_d = st_q;
        line_d = line_q;
        nb_d = nb_q;
        w_d = w_q;
        first_d = first_q;
        last_d = last_q;
        err_d = err_q;
        mode_d = mode_q;
        case (st_q)
            SPFP_H_FILL: begin
                if (i_byte_valid) begin
                    line_d[nb_q[3:0]] = i_byte_data;
                    nb_d = nb_q + 5'h01;
                    err_d = err_q || i_byte_err;
                    last_d = i_byte_last;
                    if (i_byte_last || nb_q == 5'h0f) begin
                        st_d = SPFP_H_SEND;
                        w_d = 2'h0;
                        mode_d = i_mode;
                    end
                end
            end
            SPFP_H_SEND: begin
                if (u_word.ready) begin
                    if (w_q == fw) begin
                        st_d = SPFP_H_FILL;
                        line_d = '0;
                        nb_d = '0;
                        first_d = last_q;
                        last_d = 1'b0;
                        err_d = err_q && !last_q;
                    end else begin
                        w_d = w_q + 2'h1;
                    end
                end
            end
            default: st_d = SPFP_H_FILL;
        endcase
    end

    // State registers.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st_q <= SPFP_H_FILL;
            line_q <= '0;
            nb_q <= '0;
            w_q <= '0;
            first_q <= 1'b1;
            last_q <= 1'b0;
            err_q <= 1'b0;
            mode_q <= SPFP_W32;
        end else begin
            st_q <= st_d;
            line_q <= line_d;
            nb_q <= nb_d;
            w_q <= w_d;
            first_q <= first_d;
            last_q <= last_d;
            err_q <= err_d;
            mode_q <= mode_d;
        end
    end
endmodule
`default_nettype wire

// File: logic/spfp_link_ser.sv
// Purpose: Splits a stored line into 16-bit link words.
// Assumes: A line is loaded only with at least one valid byte.
// Notes:   The link sink takes one word every cycle.
`include "spfp_regs.svh"
`default_nettype none
module spfp_link_ser (
    // Clock and reset.
    input  wire logic                       i_core_clk,
    input  wire logic                       i_srst,
    // Line handoff.
    input  wire logic                       i_load,
    input  wire spfp_pkg::spfp_line_t       i_line,
    input  wire logic [4:0]                 i_nb,
    input  wire logic                       i_sop,
    input  wire logic                       i_eop,
    input  wire logic                       i_err,
    output logic                            o_ready,
    // Link words.
    output logic [`SPFP_LINK_BITS-1:0]      o_link_data,
    output logic                            o_link_valid,
    output logic                            o_link_sop,
    output logic                            o_link_eop,
    output logic                            o_link_err,
    output logic                            o_link_pad
);
    import spfp_pkg::*;

    spfp_line_t  buf_q, buf_d;
    logic [4:0]  nb_q, nb_d;
    logic [2:0]  idx_q, idx_d;
    logic        busy_q, busy_d, sop_q, sop_d, eop_q, eop_d, err_q, err_d;
    logic [15:0] dat_q, dat_d;
    logic        val_q, val_d, osop_q, osop_d, oeop_q, oeop_d, oerr_q, oerr_d, pad_q, pad_d;
    logic        last;

    assign o_ready      = !busy_q;
    assign o_link_data  = dat_q;
    assign o_link_valid = val_q;
    assign o_link_sop   = osop_q;
    assign o_link_eop   = oeop_q;
    assign o_link_err   = oerr_q;
    assign o_link_pad   = pad_q;

    // One link word per cycle; the lower byte past the end reads as zero.
    always_comb begin
        buf_d = buf_q;
        nb_d = nb_q;
        idx_d = idx_q;
        busy_d = busy_q;
        sop_d = sop_q;
        eop_d = eop_q;
        err_d = err_q;
        val_d = 1'b0;
        dat_d = '0;
        osop_d = 1'b0;
        oeop_d = 1'b0;
        oerr_d = 1'b0;
        pad_d = 1'b0;
        last = ({1'b0, idx_q, 1'b0} + 5'h02) >= nb_q;
        if (busy_q) begin
            val_d = 1'b1;
            dat_d[15:8] = buf_q[{idx_q, 1'b0}];
            dat_d[7:0] = ({1'b0, idx_q, 1'b1} < nb_q) ? buf_q[{idx_q, 1'b1}] : `SPFP_PAD_BYTE;
            osop_d = sop_q && (idx_q == 3'h0);
            oeop_d = eop_q && last;
            oerr_d = err_q;
            pad_d = last && nb_q[0];
            if (last) begin
                busy_d = 1'b0;
            end else begin
                idx_d = idx_q + 3'h1;
            end
        end else if (i_load) begin
            buf_d = i_line;
            nb_d = i_nb;
            idx_d = '0;
            busy_d = 1'b1;
            sop_d = i_sop;
            eop_d = i_eop;
            err_d = i_err;
        end
    end

    // State registers.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            buf_q <= '0;
            nb_q <= '0;
            idx_q <= '0;
            busy_q <= 1'b0;
            sop_q <= 1'b0;
            eop_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= '0;
            val_q <= 1'b0;
            osop_q <= 1'b0;
            oeop_q <= 1'b0;
            oerr_q <= 1'b0;
            pad_q <= 1'b0;
        end else begin
            buf_q <= buf_d;
            nb_q <= nb_d;
            idx_q <= idx_d;
            busy_q <= busy_d;
            sop_q <= sop_d;
            eop_q <= eop_d;
            err_q <= err_d;
            dat_q <= dat_d;
            val_q <= val_d;
            osop_q <= osop_d;
            oeop_q <= oeop_d;
            oerr_q <= oerr_d;
            pad_q <= pad_d;
        end
    end
endmodule
`default_nettype wire

// File: logic/spfp_pkg.sv
// Purpose: Types and helper functions shared by both ends.
// Assumes: Nothing beyond the constants header.
// Notes:   Word lanes are counted from the most significant byte.
`default_nettype none
package spfp_pkg;
    typedef enum logic [1:0] {SPFP_W32, SPFP_W64, SPFP_W128} spfp_mode_t;
    typedef enum {SPFP_H_FILL, SPFP_H_SEND} spfp_hstate_t;
    typedef logic [7:0] spfp_byte_t;
    typedef logic [15:0][7:0] spfp_line_t;

    // Bytes carried by one user word in the given width mode.
    function automatic logic [4:0] spfp_word_bytes(input spfp_mode_t m);
        case (m)
            SPFP_W32: return 5'h04;
            SPFP_W64: return 5'h08;
            default:  return 5'h10;
        endcase
    endfunction

    // Index of the last word of a burst in the given width mode.
    function automatic logic [1:0] spfp_last_slot(input spfp_mode_t m);
        case (m)
            SPFP_W32: return 2'h3;
            SPFP_W64: return 2'h1;
            default:  return 2'h0;
        endcase
    endfunction

    // Run of n enables starting at the top lane of a word of wb bytes.
    function automatic logic [15:0] spfp_lead_mask(input logic [4:0] n, input logic [4:0] wb);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(wb) && i >= int'(wb) - int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Number of set enables.
    function automatic logic [4:0] spfp_ones(input logic [15:0] be);
        logic [4:0] c;
        c = '0;
        for (int i = 0; i < 16; i++) begin
            c = c + 5'(be[i]);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// File: logic/spfp_regs.svh
// Purpose: Shared constants of the word format packer.
// Assumes: Included by the packer, feeder and serializer design files of the block.
// Notes:   Definitions only.
`ifndef SPFP_REGS_SVH
`define SPFP_REGS_SVH
`define SPFP_LINE_BYTES 16
`define SPFP_LINK_BITS  16
`define SPFP_PAD_BYTE   8'h00
`define SPFP_PTR_BITS   8
`endif

// File: logic/spfp_word_if.sv
// Purpose: User word port between the fabric end and the packer end.
// Assumes: Both ends run on the same clock.
// Notes:   Narrow words use the low bits of data and enables.
`default_nettype none
interface spfp_word_if;
    import spfp_pkg::*;
    logic       valid;
    logic       ready;
    logic [127:0] data;
    logic [15:0]  byte_lane_enables;
    logic       sop;
    logic       eop;
    logic       err;
    spfp_mode_t mode;
    modport host (output valid, data, byte_lane_enables, sop, eop, err, mode, input ready);
    modport dev  (input valid, data, byte_lane_enables, sop, eop, err, mode, output ready);
endinterface
`default_nettype wire

// File: verification/spfp_fmt_props.sv
// Purpose: Checks on the user word port between the fabric end and the packer end.
// Assumes: One clock; synchronous active-high reset.
// Notes:   A small slot tracker stands in for burst counting.
`default_nettype none
module spfp_fmt_props (
    // Clock and reset.
    input wire logic                 i_core_clk,
    input wire logic                 i_srst,
    // Word port signals.
    input wire logic                 valid,
    input wire logic                 ready,
    input wire logic [127:0]         data,
    input wire logic [15:0]          byte_lane_enables,
    input wire logic                 sop,
    input wire logic                 eop,
    input wire logic                 err,
    input wire spfp_pkg::spfp_mode_t mode
);
    import spfp_pkg::*;
    // ------------------------------------------------------------
    // Burst slot tracking
    // ------------------------------------------------------------
    logic [1:0] slot_q;
    logic [1:0] slot_d;
    logic       in_pkt_q;
    logic       in_pkt_d;
    logic       take;
    assign take = valid && ready;

    // The slot restarts after the last word of a burst or an end of packet.
    always_comb begin
        slot_d   = slot_q;
        in_pkt_d = in_pkt_q;
        if (take) begin
            slot_d   = (eop || slot_q == spfp_last_slot(mode)) ? 2'h0 : slot_q + 2'h1;
            in_pkt_d = !eop;
        end
    end

    // Registers only.
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            slot_q   <= 2'h0;
            in_pkt_q <= 1'b0;
        end else begin
            slot_q   <= slot_d;
            in_pkt_q <= in_pkt_d;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    a_hold_word: assert property (valid && !ready |=> valid && $stable(data) && $stable(eop))
        else $error("word changed before it was taken");
    a_full_lanes: assert property (valid && !eop |->
        byte_lane_enables == spfp_lead_mask(spfp_word_bytes(mode), spfp_word_bytes(mode)))
        else $error("non-final word lacks full enables");
    a_eop_run: assert property (valid && eop |-> byte_lane_enables != 16'h0000 &&
        byte_lane_enables == spfp_lead_mask(spfp_ones(byte_lane_enables), spfp_word_bytes(mode)))
        else $error("final word enables not a top run");
    a_top_lane: assert property (valid && sop && mode == SPFP_W128 |-> byte_lane_enables[15])
        else $error("first byte not in lane zero");
    a_sop_slot: assert property (valid && sop |-> slot_q == 2'h0 && !in_pkt_q)
        else $error("start mark off the first burst word");
    a_open_pkt: assert property (valid && !in_pkt_q |-> sop)
        else $error("packet word without start mark");
    a_burst_run: assert property (take && !eop && slot_q != spfp_last_slot(mode) |=> valid && !sop)
        else $error("burst broken before its last word");
    a_err_held: assert property (take && err && !eop |=> err || !valid)
        else $error("error flag dropped before end of packet");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Drives packets into the fabric end and checks the link words of the packer end.
// Assumes: Link words arrive in order with no back-pressure.
// Notes:   Lengths straddle line boundaries so odd tails occur in every mode and early ends in the two narrow modes.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spfp_pkg::*;
    logic        i_core_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_byte_valid = 1'b0;
    logic        i_byte_last = 1'b0;
    logic        i_byte_err = 1'b0;
    logic [7:0]  i_byte_data = 8'h00;
    spfp_mode_t  i_mode = SPFP_W32;
    logic        o_byte_ready, o_link_valid, o_link_sop, o_link_eop, o_link_err, o_link_pad, o_fmt_err;
    logic [15:0] o_link_data;
    logic [7:0]  o_wr_ptr;
    logic        i_fmt_err_clr = 1'b0;
    logic [10:0] exp_q[$];
    int          err_count = 0, cmp_count = 0, cyc = 0, lines = 0;
    int          corner[6] = '{1, 5, 15, 16, 17, 33};
    integer      seed = 32'hb2d7;

    always #10 i_core_clk = ~i_core_clk;

    // ------------------------------------------------------------
    // Both ends joined by the word port
    // ------------------------------------------------------------
    spfp_word_if i_spfp_word_if ();
    spfp_host_feeder i_spfp_host_feeder (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .i_byte_valid(i_byte_valid), .o_byte_ready(o_byte_ready), .i_byte_data(i_byte_data),
        .i_byte_last(i_byte_last), .i_byte_err(i_byte_err), .i_mode(i_mode), .u_word(i_spfp_word_if.host));
    spfp_dev_packer i_spfp_dev_packer (.i_core_clk(i_core_clk), .i_srst(i_srst), .u_word(i_spfp_word_if.dev),
        .o_link_data(o_link_data), .o_link_valid(o_link_valid), .o_link_sop(o_link_sop),
        .o_link_eop(o_link_eop), .o_link_err(o_link_err), .o_link_pad(o_link_pad),
        .o_wr_ptr(o_wr_ptr), .o_fmt_err(o_fmt_err), .i_fmt_err_clr(i_fmt_err_clr));
    spfp_fmt_props i_spfp_fmt_props (.i_core_clk(i_core_clk), .i_srst(i_srst),
        .valid(i_spfp_word_if.valid), .ready(i_spfp_word_if.ready), .data(i_spfp_word_if.data),
        .byte_lane_enables(i_spfp_word_if.byte_lane_enables), .sop(i_spfp_word_if.sop),
        .eop(i_spfp_word_if.eop), .err(i_spfp_word_if.err), .mode(i_spfp_word_if.mode));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang is cut well beyond the thousand or so cycles the run needs.
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    // Lines a packet of len bytes fills: sixteen bytes a line, the tail in a line of its own.
    function automatic int line_count(input int len);
        return (len + 15) / 16;
    endfunction

    // Each queued entry is first flag, error flag, last flag and byte; the byte is held until taken.
    task automatic send_pkt(input int len, input int m, input logic e);
        logic [7:0] b;
        for (int k = 0; k < len; k++) begin
            b = 8'($random(seed));
            i_byte_valid <= 1'b1;
            i_byte_data  <= b;
            i_byte_last  <= (k == len - 1);
            i_byte_err   <= e;
            i_mode       <= spfp_mode_t'(m);
            exp_q.push_back({k == 0, e, k == len - 1, b});
            @(negedge i_core_clk);
            while (o_byte_ready !== 1'b1) @(negedge i_core_clk);
            @(posedge i_core_clk);
        end
        i_byte_valid <= 1'b0;
        lines += line_count(len);
        // One idle edge, so the next packet never drives valid twice in one time step.
        @(posedge i_core_clk);
    endtask

    // Rebuild the bytes from link words; the lower half is payload unless marked as pad.
    always @(posedge i_core_clk) begin
        logic [10:0] e;
        if (!i_srst && o_link_valid === 1'b1) begin
            e = exp_q.pop_front();
            chk(16'(o_link_sop), 16'(e[10]));
            chk(16'(o_link_data[15:8]), 16'(e[7:0]));
            chk(16'(o_link_err), 16'(e[9]));
            if (o_link_pad === 1'b1) begin
                chk(16'(o_link_data[7:0]), 16'h0000);
                chk(16'(e[8]), 16'h0001);
            end else if (!e[8]) begin
                e = exp_q.pop_front();
                chk(16'(o_link_data[7:0]), 16'(e[7:0]));
            end
            chk(16'(o_link_eop), 16'(e[8]));
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_core_clk);
        i_srst <= 1'b0;
        for (int m = 0; m < 3; m++) begin
            foreach (corner[i]) send_pkt(corner[i], m, 1'(i));
        end
        for (int n = 0; n < 12; n++) begin
            send_pkt(1 + int'($unsigned($random(seed)) % 48), int'($unsigned($random(seed)) % 3), 1'($random(seed)));
        end
        for (int w = 0; w < 300 && exp_q.size() > 0; w++) @(posedge i_core_clk);
        repeat (4) @(posedge i_core_clk);
        chk(16'(exp_q.size()), 16'h0000);
        chk(16'(o_wr_ptr), 16'(lines[7:0]));
        chk(16'(o_fmt_err), 16'h0000);
        // A clear pulse with no violation pending must leave the flag low.
        i_fmt_err_clr <= 1'b1;
        @(posedge i_core_clk);
        i_fmt_err_clr <= 1'b0;
        @(posedge i_core_clk);
        chk(16'(o_fmt_err), 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
